// *** hdl/sli_regs.vh ***
// constants for the status indicator driver: map, fields, codes, timing
`ifndef SLI_REGS_VH
`define SLI_REGS_VH

// ============================================================
// clock and time base
`define SLI_CLK_KHZ          100000
`define SLI_HALF_SEC_MS      500
`define SLI_HALF_SEC_CYCLES  (`SLI_HALF_SEC_MS * `SLI_CLK_KHZ)
`define SLI_TICK_W           26
`define SLI_STARTUP_SLOTS    8'h14

// ============================================================
// register map (byte addresses)
`define SLI_ADDR_W           8
`define SLI_DATA_W           32
`define SLI_ADR_STATUS       8'h00
`define SLI_ADR_MASK         8'h04
`define SLI_ADR_STATE        8'h08
`define SLI_ADR_CTRL         8'h0C

// status / mask bits
`define SLI_EV_W             3
`define SLI_EV_SYS_CHG       0
`define SLI_EV_APP_CHG       1
`define SLI_EV_HW_FAIL       2

// control bits and reset value
`define SLI_CTRL_W           2
`define SLI_CTRL_ENABLE      0
`define SLI_CTRL_TEST        1
`define SLI_CTRL_RST         2'h1

// state register fields
`define SLI_ST_SYS_LSB       0
`define SLI_ST_APP_LSB       4
`define SLI_ST_HWF_BIT       8

// ============================================================
// condition inputs, one bit each after synchronising
`define SLI_IN_W             10
`define SLI_IN_BOOT          0
`define SLI_IN_NOFW          1
`define SLI_IN_OSRUN         2
`define SLI_IN_INIT          3
`define SLI_IN_PRI_CYC       4
`define SLI_IN_SEC_CYC       5
`define SLI_IN_GW_RUN        6
`define SLI_IN_PRI_CFG       7
`define SLI_IN_SEC_CFG       8
`define SLI_IN_INIT_ERR      9

// ============================================================
// system indicator modes
`define SLI_SYS_W            2
`define SLI_SYS_BOOT         2'h0
`define SLI_SYS_NOFW         2'h1
`define SLI_SYS_RUN          2'h2
`define SLI_SYS_START        2'h3

// application indicator modes
`define SLI_APP_W            3
`define SLI_APP_OFF          3'h0
`define SLI_APP_GRN_ON       3'h1
`define SLI_APP_GRN_SGL      3'h2
`define SLI_APP_GRN_DBL      3'h3
`define SLI_APP_RED_SGL      3'h4
`define SLI_APP_RED_DBL      3'h5
`define SLI_APP_RED_ON       3'h6

// blink pattern slots of half a second each
`define SLI_SLOT_W           3
`define SLI_SGL_LEN          3'h5
`define SLI_DBL_LEN          3'h7
`define SLI_SLOT_ON1         3'h4
`define SLI_SLOT_ON2         3'h6

`endif

// *** hdl/sli_status_led.v ***
// front-panel system and application indicator driver with register port
`timescale 1ns/100ps
`include "sli_regs.vh"
module sli_status_led
#(
    parameter HALF_SEC_CYCLES = `SLI_HALF_SEC_CYCLES
)
(
    // clock, reset, enable
    input  wire                   sys_clk,
    input  wire                   resetn,
    input  wire                   ce,
    // status conditions from firmware logic (asynchronous)
    input  wire                   boot_active,
    input  wire                   no_firmware,
    input  wire                   os_running,
    input  wire                   initialized,
    input  wire                   primary_port_cyclic,
    input  wire                   secondary_port_cyclic,
    input  wire                   gateway_running,
    input  wire                   primary_port_cfg_err,
    input  wire                   secondary_port_cfg_err,
    input  wire                   init_err,
    // register port
    input  wire [`SLI_ADDR_W-1:0] reg_addr,
    input  wire [`SLI_DATA_W-1:0] reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [`SLI_DATA_W-1:0] reg_rdata,
    // interrupt
    output reg                    irq,
    // indicator drives
    output reg                    system_indicator_green,
    output reg                    system_indicator_yellow,
    output reg                    application_indicator_green,
    output reg                    application_indicator_red
);

    // ============================================================
    // functions
    function is_on;
        input [`SLI_SLOT_W-1:0] slot;
        input                   dbl;
        begin
            is_on = (slot == `SLI_SLOT_ON1) || (dbl && (slot == `SLI_SLOT_ON2));
        end
    endfunction

    function [`SLI_SLOT_W-1:0] slot_len;
        input dbl;
        begin
            slot_len = dbl ? `SLI_DBL_LEN : `SLI_SGL_LEN;
        end
    endfunction

    // ============================================================
    // declarations
    wire [`SLI_IN_W-1:0]   cond;
    reg  [`SLI_TICK_W-1:0] tick_cnt_r;
    reg                    half_tick;
    reg                    phase_r;
    reg  [`SLI_SLOT_W-1:0] slot_r;
    reg  [`SLI_SLOT_W-1:0] slot_nxt;
    reg  [`SLI_SYS_W-1:0]  sys_mode_r;
    reg  [`SLI_SYS_W-1:0]  sys_mode_nxt;
    reg  [`SLI_APP_W-1:0]  app_mode_r;
    reg  [`SLI_APP_W-1:0]  app_mode_nxt;
    reg  [7:0]             start_cnt_r;
    reg                    hw_fail_r;
    reg  [`SLI_EV_W-1:0]   status_r;
    reg  [`SLI_EV_W-1:0]   status_nxt;
    reg  [`SLI_EV_W-1:0]   mask_r;
    reg  [`SLI_CTRL_W-1:0] ctrl_r;
    reg  [`SLI_EV_W-1:0]   events;
    reg  [`SLI_DATA_W-1:0] rd_val;
    reg                    app_mode_chg;
    reg                    sys_g_nxt;
    reg                    sys_y_nxt;
    reg                    app_g_nxt;
    reg                    app_r_nxt;

    localparam integer           TICK_LAST_I = HALF_SEC_CYCLES - 1;
    localparam [`SLI_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`SLI_TICK_W-1:0];

    // ============================================================
    // input synchronisers
    sli_sync
    #(
        .W (`SLI_IN_W)
    )
    u_sync
    (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .ce       (ce),
        .async_in ({init_err, secondary_port_cfg_err, primary_port_cfg_err,
                    gateway_running, secondary_port_cyclic, primary_port_cyclic,
                    initialized, os_running, no_firmware, boot_active}),
        .sync_out (cond)
    );

    // ============================================================
    // system indicator mode
    always @*
    begin
        if (cond[`SLI_IN_NOFW])
            sys_mode_nxt = `SLI_SYS_NOFW;
        else if (cond[`SLI_IN_BOOT])
            sys_mode_nxt = `SLI_SYS_BOOT;
        else if (cond[`SLI_IN_OSRUN])
            sys_mode_nxt = `SLI_SYS_RUN;
        else
            sys_mode_nxt = `SLI_SYS_START;
    end

    // ============================================================
    // application indicator mode, in priority order
    always @*
    begin
        if (cond[`SLI_IN_INIT_ERR])
            app_mode_nxt = `SLI_APP_RED_ON;
        else if (!cond[`SLI_IN_INIT])
            app_mode_nxt = `SLI_APP_OFF;
        else if (cond[`SLI_IN_PRI_CFG])
            app_mode_nxt = `SLI_APP_RED_SGL;
        else if (cond[`SLI_IN_SEC_CFG])
            app_mode_nxt = `SLI_APP_RED_DBL;
        else if (!cond[`SLI_IN_PRI_CYC])
            app_mode_nxt = `SLI_APP_GRN_SGL;
        else if (!cond[`SLI_IN_SEC_CYC])
            app_mode_nxt = `SLI_APP_GRN_DBL;
        else if (cond[`SLI_IN_GW_RUN])
            app_mode_nxt = `SLI_APP_GRN_ON;
        else
            app_mode_nxt = `SLI_APP_OFF;
        app_mode_chg = (app_mode_nxt != app_mode_r);
    end

    // ============================================================
    // half-second time base and pattern slot
    always @*
    begin
        half_tick = (tick_cnt_r == TICK_LAST);
        slot_nxt  = slot_r;
        if (app_mode_chg)
            slot_nxt = {`SLI_SLOT_W{1'b0}};
        else if (half_tick)
        begin
            if (slot_r == slot_len((app_mode_r == `SLI_APP_GRN_DBL) ||
                                   (app_mode_r == `SLI_APP_RED_DBL)) - 3'h1)
                slot_nxt = {`SLI_SLOT_W{1'b0}};
            else
                slot_nxt = slot_r + 3'h1;
        end
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_cnt_r <= {`SLI_TICK_W{1'b0}};
            phase_r    <= 1'b0;
            slot_r     <= {`SLI_SLOT_W{1'b0}};
        end
        else if (ce)
        begin
            // a new pattern restarts at its off phase
            if (half_tick || app_mode_chg)
                tick_cnt_r <= {`SLI_TICK_W{1'b0}};
            else
                tick_cnt_r <= tick_cnt_r + 26'h1;
            if (half_tick)
                phase_r <= ~phase_r;
            slot_r <= slot_nxt;
        end
    end

    // ============================================================
    // start-up watchdog on steady yellow
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            start_cnt_r <= 8'h00;
            hw_fail_r   <= 1'b0;
        end
        else if (ce)
        begin
            if (sys_mode_r != `SLI_SYS_START)
            begin
                start_cnt_r <= 8'h00;
                hw_fail_r   <= 1'b0;
            end
            else if (half_tick && !hw_fail_r)
            begin
                if (start_cnt_r == `SLI_STARTUP_SLOTS - 8'h01)
                    hw_fail_r <= 1'b1;
                start_cnt_r <= start_cnt_r + 8'h01;
            end
        end
    end

    // ============================================================
    // indicator outputs
    always @*
    begin
        sys_g_nxt = 1'b0;
        sys_y_nxt = 1'b0;
        case (sys_mode_r)
            `SLI_SYS_BOOT:
            begin
                sys_y_nxt = ~phase_r;
                sys_g_nxt = phase_r;
            end
            `SLI_SYS_NOFW:  sys_y_nxt = phase_r;
            `SLI_SYS_RUN:   sys_g_nxt = 1'b1;
            `SLI_SYS_START: sys_y_nxt = 1'b1;
            default:        sys_y_nxt = 1'b0;
        endcase
        app_g_nxt = 1'b0;
        app_r_nxt = 1'b0;
        case (app_mode_r)
            `SLI_APP_GRN_ON:  app_g_nxt = 1'b1;
            `SLI_APP_GRN_SGL: app_g_nxt = is_on(slot_r, 1'b0);
            `SLI_APP_GRN_DBL: app_g_nxt = is_on(slot_r, 1'b1);
            `SLI_APP_RED_SGL: app_r_nxt = is_on(slot_r, 1'b0);
            `SLI_APP_RED_DBL: app_r_nxt = is_on(slot_r, 1'b1);
            `SLI_APP_RED_ON:  app_r_nxt = 1'b1;
            default:          app_r_nxt = 1'b0;
        endcase
        // lamp test lights every element, disable blanks them
        if (ctrl_r[`SLI_CTRL_TEST])
        begin
            sys_g_nxt = 1'b1;
            sys_y_nxt = 1'b1;
            app_g_nxt = 1'b1;
            app_r_nxt = 1'b1;
        end
        else if (!ctrl_r[`SLI_CTRL_ENABLE])
        begin
            sys_g_nxt = 1'b0;
            sys_y_nxt = 1'b0;
            app_g_nxt = 1'b0;
            app_r_nxt = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sys_mode_r                  <= `SLI_SYS_START;
            app_mode_r                  <= `SLI_APP_OFF;
            system_indicator_green      <= 1'b0;
            system_indicator_yellow     <= 1'b0;
            application_indicator_green <= 1'b0;
            application_indicator_red   <= 1'b0;
        end
        else if (ce)
        begin
            sys_mode_r                  <= sys_mode_nxt;
            app_mode_r                  <= app_mode_nxt;
            system_indicator_green      <= sys_g_nxt;
            system_indicator_yellow     <= sys_y_nxt;
            application_indicator_green <= app_g_nxt;
            application_indicator_red   <= app_r_nxt;
        end
    end

    // ============================================================
    // events, sticky status and interrupt
    always @*
    begin
        events                   = {`SLI_EV_W{1'b0}};
        events[`SLI_EV_SYS_CHG]  = (sys_mode_nxt != sys_mode_r);
        events[`SLI_EV_APP_CHG]  = app_mode_chg;
        events[`SLI_EV_HW_FAIL]  = half_tick && !hw_fail_r &&
                                   (sys_mode_r == `SLI_SYS_START) &&
                                   (start_cnt_r == `SLI_STARTUP_SLOTS - 8'h01);
        status_nxt = status_r;
        if (reg_wr && (reg_addr == `SLI_ADR_STATUS))
            status_nxt = status_r & ~reg_wdata[`SLI_EV_W-1:0];
        // a new event wins over a clear in the same cycle
        status_nxt = status_nxt | events;
    end

    // ============================================================
    // register read mux
    always @*
    begin
        rd_val = {`SLI_DATA_W{1'b0}};
        case (reg_addr)
            `SLI_ADR_STATUS: rd_val[`SLI_EV_W-1:0]   = status_r;
            `SLI_ADR_MASK:   rd_val[`SLI_EV_W-1:0]   = mask_r;
            `SLI_ADR_CTRL:   rd_val[`SLI_CTRL_W-1:0] = ctrl_r;
            `SLI_ADR_STATE:
            begin
                rd_val[`SLI_ST_SYS_LSB +: `SLI_SYS_W] = sys_mode_r;
                rd_val[`SLI_ST_APP_LSB +: `SLI_APP_W] = app_mode_r;
                rd_val[`SLI_ST_HWF_BIT]               = hw_fail_r;
            end
            default:         rd_val = {`SLI_DATA_W{1'b0}};
        endcase
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_r  <= {`SLI_EV_W{1'b0}};
            mask_r    <= {`SLI_EV_W{1'b0}};
            ctrl_r    <= `SLI_CTRL_RST;
            reg_rdata <= {`SLI_DATA_W{1'b0}};
            irq       <= 1'b0;
        end
        else if (ce)
        begin
            status_r <= status_nxt;
            if (reg_wr && (reg_addr == `SLI_ADR_MASK))
                mask_r <= reg_wdata[`SLI_EV_W-1:0];
            if (reg_wr && (reg_addr == `SLI_ADR_CTRL))
                ctrl_r <= reg_wdata[`SLI_CTRL_W-1:0];
            reg_rdata <= reg_rd ? rd_val : {`SLI_DATA_W{1'b0}};
            irq       <= |(status_nxt & mask_r);
        end
    end

endmodule

// *** hdl/sli_sync.v ***
// three-stage input synchroniser that passes a bit once stages two and three agree
`timescale 1ns/100ps
module sli_sync
#(
    parameter W = 1
)
(
    // clock, reset, enable
    input  wire         sys_clk,
    input  wire         resetn,
    input  wire         ce,
    // asynchronous in, synchronous out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;

    // ============================================================
    // stages
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r     <= {W{1'b0}};
            s2_r     <= {W{1'b0}};
            s3_r     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else if (ce)
        begin
            s1_r     <= async_in;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            // a bit only moves once two stages hold the same value
            sync_out <= (sync_out & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        end
    end

endmodule

// *** tb/sli_status_led_asserts.sv ***
// property checker for the front-panel indicator driver
`timescale 1ns/100ps
`include "sli_regs.vh"
module sli_status_led_asserts
#(
    parameter HALF_SEC_CYCLES = 20
)
(
    // clock and reset
    input wire        sys_clk,
    input wire        resetn,
    input wire        ce,
    // conditions
    input wire        boot_active,
    input wire        no_firmware,
    input wire        os_running,
    input wire        initialized,
    input wire        primary_port_cyclic,
    input wire        secondary_port_cyclic,
    input wire        gateway_running,
    input wire        primary_port_cfg_err,
    input wire        secondary_port_cfg_err,
    input wire        init_err,
    // register port and interrupt
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        irq,
    // indicators
    input wire        system_indicator_green,
    input wire        system_indicator_yellow,
    input wire        application_indicator_green,
    input wire        application_indicator_red
);
    // ============================================================
    // length of the current red lit phase
    reg [31:0] red_run_r;
    always @(posedge sys_clk or negedge resetn)
        if (!resetn)
            red_run_r <= 32'h0;
        else if (ce)
            red_run_r <= application_indicator_red ? red_run_r + 32'h1 : 32'h0;

    // ============================================================
    // properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_run_held;
        (ce && os_running && !boot_active && !no_firmware)[*8];
    endsequence
    sequence s_cfg_fault_held;
        (ce && initialized && !init_err && (primary_port_cfg_err || secondary_port_cfg_err))[*8];
    endsequence
    sequence s_mask_off;
        ce && reg_wr && reg_addr == `SLI_ADR_MASK && reg_wdata[2:0] == 3'h0;
    endsequence

    a_rdata_idle_zero: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer cycle");
    a_irq_mask_off: assert property (s_mask_off |-> ##2 !irq)
        else $error("interrupt still high after mask cleared");
    a_sys_run_green: assert property (s_run_held |-> system_indicator_green && !system_indicator_yellow)
        else $error("system indicator not steady green while running");
    a_nofw_no_green: assert property ((ce && no_firmware)[*8] |-> !system_indicator_green)
        else $error("green shown with no firmware");
    a_boot_one_colour: assert property ((ce && boot_active && !no_firmware)[*8] |->
        system_indicator_green != system_indicator_yellow)
        else $error("boot indicator not alternating single colour");
    a_init_err_red: assert property ((ce && init_err)[*8] |->
        application_indicator_red && !application_indicator_green)
        else $error("application indicator not steady red on init error");
    a_all_cyclic_green: assert property ((ce && initialized && primary_port_cyclic &&
        secondary_port_cyclic && gateway_running && !primary_port_cfg_err &&
        !secondary_port_cfg_err && !init_err)[*8] |->
        application_indicator_green && !application_indicator_red)
        else $error("application indicator not steady green in exchange");
    a_no_fault_no_red: assert property ((ce && initialized && !init_err && !primary_port_cfg_err
        && !secondary_port_cfg_err)[*8] |-> !application_indicator_red)
        else $error("red shown without a fault");
    a_red_pulse_width: assert property (s_cfg_fault_held ##0 $fell(application_indicator_red)
        |-> red_run_r == HALF_SEC_CYCLES)
        else $error("red blink phase length wrong");
endmodule

bind sli_status_led sli_status_led_asserts #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) chk_u
(
    .sys_clk, .resetn, .ce, .boot_active, .no_firmware, .os_running, .initialized,
    .primary_port_cyclic, .secondary_port_cyclic, .gateway_running, .primary_port_cfg_err,
    .secondary_port_cfg_err, .init_err, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .system_indicator_green, .system_indicator_yellow, .application_indicator_green,
    .application_indicator_red
);

// *** tb/testbench.sv ***
// self-checking bench for the front-panel indicator driver
`timescale 1ns/100ps
`include "sli_regs.vh"
module testbench;
    localparam integer HALF = 20;
    localparam integer WIN  = 70 * HALF;
    reg         sys_clk;
    reg         resetn;
    reg         ce;
    reg  [9:0]  cond;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [31:0] reg_rdata;
    wire        irq;
    wire        sys_grn;
    wire        sys_yel;
    wire        app_grn;
    wire        app_red;
    reg  [31:0] rdv;
    integer     bad_count;
    integer     checks_done;
    integer     cycles;
    integer     n_sg;
    integer     n_sy;
    integer     n_ag;
    integer     n_ar;

    sli_status_led #(.HALF_SEC_CYCLES(HALF)) dut_u
    (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .boot_active(cond[`SLI_IN_BOOT]), .no_firmware(cond[`SLI_IN_NOFW]),
        .os_running(cond[`SLI_IN_OSRUN]), .initialized(cond[`SLI_IN_INIT]),
        .primary_port_cyclic(cond[`SLI_IN_PRI_CYC]), .secondary_port_cyclic(cond[`SLI_IN_SEC_CYC]),
        .gateway_running(cond[`SLI_IN_GW_RUN]), .primary_port_cfg_err(cond[`SLI_IN_PRI_CFG]),
        .secondary_port_cfg_err(cond[`SLI_IN_SEC_CFG]), .init_err(cond[`SLI_IN_INIT_ERR]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq),
        .system_indicator_green(sys_grn), .system_indicator_yellow(sys_yel),
        .application_indicator_green(app_grn), .application_indicator_red(app_red)
    );

    // ============================================================
    // common tasks
    task end_of_test;
        begin
            if (bad_count == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge sys_clk);
            reg_wr    <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge sys_clk);
            reg_rd   <= 1'b0;
            #1;
            rdv = reg_rdata;
        end
    endtask
    task apply(input [9:0] v);
        begin
            @(posedge sys_clk);
            cond <= v;
            repeat (10) @(posedge sys_clk);
            #1;
        end
    endtask
    // counts lit cycles of every indicator over n cycles
    task measure(input integer n);
        integer i;
        begin
            n_sg = 0;
            n_sy = 0;
            n_ag = 0;
            n_ar = 0;
            for (i = 0; i < n; i = i + 1)
            begin
                @(posedge sys_clk);
                #1;
                n_sg = n_sg + sys_grn;
                n_sy = n_sy + sys_yel;
                n_ag = n_ag + app_grn;
                n_ar = n_ar + app_red;
            end
        end
    endtask

    // ============================================================
    // scenarios
    task t_startup;
        begin
            measure(200);
            chk(n_sy, 200);
            chk(n_sg, 0);
            rd(`SLI_ADR_STATE);
            chk(rdv & 32'h73, 32'h03);
        end
    endtask
    task t_regs;
        begin
            rd(`SLI_ADR_MASK);
            chk(rdv, 32'h0);
            rd(`SLI_ADR_CTRL);
            chk(rdv, 32'h1);
            wr(8'h10, 32'h5);
            rd(8'h10);
            chk(rdv, 32'h0);
            wr(`SLI_ADR_MASK, 32'h7);
            rd(`SLI_ADR_MASK);
            chk(rdv, 32'h7);
            wr(`SLI_ADR_MASK, 32'h0);
            wr(`SLI_ADR_STATE, 32'hFFFF);
            rd(`SLI_ADR_STATE);
            chk(rdv & 32'h73, 32'h03);
            @(posedge sys_clk);
            #1;
            chk(reg_rdata, 32'h0);
        end
    endtask
    task t_irq;
        begin
            repeat (300) @(posedge sys_clk);
            rd(`SLI_ADR_STATUS);
            chk(rdv & 32'h4, 32'h4);
            rd(`SLI_ADR_STATE);
            chk(rdv & 32'h100, 32'h100);
            chk({31'h0, irq}, 32'h0);
            wr(`SLI_ADR_MASK, 32'h4);
            repeat (2) @(posedge sys_clk);
            #1;
            chk({31'h0, irq}, 32'h1);
            wr(`SLI_ADR_STATUS, 32'h4);
            repeat (2) @(posedge sys_clk);
            #1;
            chk({31'h0, irq}, 32'h0);
            wr(`SLI_ADR_MASK, 32'h2);
            apply(10'h078);
            chk({31'h0, irq}, 32'h1);
            wr(`SLI_ADR_MASK, 32'h0);
            repeat (2) @(posedge sys_clk);
            #1;
            chk({31'h0, irq}, 32'h0);
            wr(`SLI_ADR_STATUS, 32'h7);
        end
    endtask
    task t_ctrl;
        begin
            apply(10'h0);
            wr(`SLI_ADR_CTRL, 32'h0);
            repeat (3) @(posedge sys_clk);
            measure(40);
            chk(n_sg + n_sy + n_ag + n_ar, 0);
            wr(`SLI_ADR_CTRL, 32'h3);
            repeat (3) @(posedge sys_clk);
            measure(40);
            chk(n_sg + n_sy + n_ag + n_ar, 160);
            // a write while the enable is low must not be taken
            @(posedge sys_clk);
            ce <= 1'b0;
            wr(`SLI_ADR_CTRL, 32'h1);
            ce <= 1'b1;
            repeat (3) @(posedge sys_clk);
            measure(40);
            chk(n_sg + n_sy + n_ag + n_ar, 160);
            wr(`SLI_ADR_CTRL, 32'h1);
            rd(`SLI_ADR_CTRL);
            chk(rdv, 32'h1);
        end
    endtask
    task sys_case(input [2:0] c, input [31:0] eg, input [31:0] ey, input [31:0] m);
        begin
            apply(10'h0);
            apply({7'h0, c});
            measure(WIN);
            chk(n_sg, eg);
            chk(n_sy, ey);
            rd(`SLI_ADR_STATE);
            chk(rdv & 32'h3, m);
        end
    endtask
    task app_case(input [6:0] c, input [31:0] eg, input [31:0] er, input [31:0] m);
        begin
            apply(10'h004);
            apply({c, 3'h4});
            measure(WIN);
            chk(n_ag, eg);
            chk(n_ar, er);
            chk(n_sg, WIN);
            rd(`SLI_ADR_STATE);
            chk(rdv & 32'h70, m << 4);
        end
    endtask

    // ============================================================
    // clock, timeout, main sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end
    initial
    begin
        bad_count   = 0;
        checks_done = 0;
        cycles      = 0;
        resetn      = 1'b0;
        ce          = 1'b1;
        cond        = 10'h0;
        reg_addr    = 8'h0;
        reg_wdata   = 32'h0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_startup;
        t_regs;
        t_irq;
        t_ctrl;
        sys_case(3'b001, WIN / 2, WIN / 2, 0);
        sys_case(3'b010, 0, WIN / 2, 1);
        sys_case(3'b011, 0, WIN / 2, 1);
        sys_case(3'b100, WIN, 0, 2);
        sys_case(3'b101, WIN / 2, WIN / 2, 0);
        app_case(7'h0F, WIN, 0, 1);
        app_case(7'h07, 0, 0, 0);
        app_case(7'h0E, 0, 0, 0);
        app_case(7'h0D, WIN / 5, 0, 2);
        app_case(7'h0B, 2 * WIN / 7, 0, 3);
        app_case(7'h09, WIN / 5, 0, 2);
        app_case(7'h1F, 0, WIN / 5, 4);
        app_case(7'h2F, 0, 2 * WIN / 7, 5);
        app_case(7'h39, 0, WIN / 5, 4);
        app_case(7'h2D, 0, 2 * WIN / 7, 5);
        app_case(7'h7F, 0, WIN, 6);
        app_case(7'h40, 0, WIN, 6);
        end_of_test;
    end
endmodule
